//--- rtl/timer_pkg.sv
// Shared constants of the timer channel block: register offsets,
// field positions, values after reset and bus answer codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.

package timer_pkg;

   // Byte address width of the register window
   localparam int ADDR_W = 8;

   // Register byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFF_OE    = 8'h00; // timer_output_enable
   localparam logic [ADDR_W-1:0] OFF_OUT   = 8'h04; // Channel output bits
   localparam logic [ADDR_W-1:0] OFF_IFL   = 8'h08; // irq_request_flags_low
   localparam logic [ADDR_W-1:0] OFF_MKL   = 8'h0C; // irq_mask_flags_low
   localparam logic [ADDR_W-1:0] OFF_MKH   = 8'h10; // irq_mask_flags_high
   localparam logic [ADDR_W-1:0] OFF_START = 8'h14; // channel_start_trigger_high
   localparam logic [ADDR_W-1:0] OFF_STOP  = 8'h18; // Channel stop trigger
   localparam logic [ADDR_W-1:0] OFF_MODE  = 8'h1C; // Start mode per channel
   localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h20; // Count enabled status
   localparam logic [ADDR_W-1:0] OFF_PER0  = 8'h24; // Period, channel 0
   localparam logic [ADDR_W-1:0] OFF_CNT0  = 8'h34; // Counter, channel 0
   localparam logic [ADDR_W-1:0] CHAN_STEP = 8'h04; // Stride per channel

   // Bit positions in the request and mask registers
   localparam int IRQ_CH0_BIT  = 7; // chan0 done request / chan0_done_mask
   localparam int IRQ_CH1_BIT  = 6; // chan1_done_request / chan1_done_mask
   localparam int IRQ_EXT0_BIT = 1; // External pin 0 request / ext_pin0_mask
   localparam int MKH_CH1_BIT  = 0; // chan1_low_done_mask

   // Values after reset
   localparam logic [7:0] IFL_RST  = 8'h00; // No pending requests
   localparam logic [7:0] MKL_IMPL = 8'hC2; // Implemented mask bits
   localparam logic [7:0] MKL_RST  = 8'hC2; // All sources masked
   localparam logic [7:0] MKH_FIX  = 8'hF8; // Upper bits read as one
   localparam logic       MKH_RST  = 1'b1;  // chan1_low_done_mask set

   // Count clock divider: system clocks per count clock
   localparam int COUNT_DIV_DEF = 1;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- rtl/chan_counter.sv
// One timer channel counter in interval mode: load, count down,
// reload and pulse done when the count passes zero.
// Assumes go_i and period_i come from registers in the clock domain.

`timescale 1ns/10ps
`default_nettype none

module chan_counter #(
   parameter int PER_W = 8
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             go_i,     // Channel may count
   input  wire logic             tick_i,   // One count clock
   input  wire logic [PER_W-1:0] period_i, // Reload value
   output var  logic             done_o,   // Interval complete pulse
   output var  logic [PER_W-1:0] count_o   // Current counter value
);

   typedef enum logic [0:0] {S_IDLE, S_RUN} cnt_state_t;

   cnt_state_t       state_q;   // Idle until the first count clock
   logic [PER_W-1:0] ld_q;      // Value loaded last, for checking
   logic [PER_W-1:0] ticks_q;   // Ticks since load or reload

   ////////////////////////////////////////////////////////////////////
   // Counter: first tick loads, then value+1 ticks per interval
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         count_o <= '0;
         done_o  <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (state_q)
            S_IDLE: begin
               // Load on a count clock, not on the enable itself
               if (go_i && tick_i) begin
                  count_o <= period_i;
                  state_q <= S_RUN;
               end
            end
            S_RUN: begin
               if (!go_i) begin
                  state_q <= S_IDLE;
               end else if (tick_i) begin
                  if (count_o == '0) begin
                     count_o <= period_i;
                     done_o  <= 1'b1;
                  end else begin
                     count_o <= count_o - 1'b1;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checking helpers: interval length in ticks
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ld_q    <= '0;
         ticks_q <= '0;
      end else if (ce_i && tick_i && go_i) begin
         if (state_q == S_IDLE || count_o == '0) begin
            ld_q    <= period_i;
            ticks_q <= '0;
         end else begin
            ticks_q <= ticks_q + 1'b1;
         end
      end
   end

   interval_len_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && tick_i && go_i && state_q == S_RUN && count_o == '0)
      |-> ticks_q == ld_q)
      else $error("interval is not period plus one count clocks");

   reload_done_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && tick_i && go_i && state_q == S_RUN && count_o == '0)
      |=> done_o && count_o == $past(period_i))
      else $error("completion did not reload and pulse done");

endmodule

`default_nettype wire

//--- rtl/timer_channel_output_irq_ctrl.sv
// Timer channel control: periods, output enables, start and stop,
// completion requests with masks, and an AXI4-Lite register slave.
// Assumes one clock, synchronous inputs and a single-beat master.

`timescale 1ns/10ps
`default_nettype none

module timer_channel_output_irq_ctrl
   import timer_pkg::*;
#(
   parameter int NUM_CHAN  = 2,            // 2, or 4 on larger parts
   parameter int PER_W     = 8,            // Period width, up to 8
   parameter int COUNT_DIV = COUNT_DIV_DEF // Clocks per count clock
) (
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              ext_pin0_i,
   input  wire logic              s_axi_awvalid_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   output var  logic              s_axi_awready_o,
   input  wire logic              s_axi_wvalid_i,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   output var  logic              s_axi_wready_o,
   output var  logic              s_axi_bvalid_o,
   output var  logic [1:0]        s_axi_bresp_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic              s_axi_arvalid_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   output var  logic              s_axi_arready_o,
   output var  logic              s_axi_rvalid_o,
   output var  logic [31:0]       s_axi_rdata_o,
   output var  logic [1:0]        s_axi_rresp_o,
   input  wire logic              s_axi_rready_i,
   output var  logic [NUM_CHAN-1:0] tout_o,
   output var  logic              irq_o
);

   localparam logic [15:0] DIV_LAST = 16'(COUNT_DIV - 1);

   // Word-aligned address compare, shared by both bus sides
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      return a[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction

   // Offset of a per-channel register
   function automatic logic [ADDR_W-1:0] chan_off(
      input logic [ADDR_W-1:0] base, input int ch);
      return base + ADDR_W'(ch) * CHAN_STEP;
   endfunction

   logic              aw_q;        // Write address held
   logic [ADDR_W-1:0] awaddr_q;    // Held write address
   logic              w_q;         // Write data held
   logic [7:0]        wdata_q;     // Held low data byte
   logic              wstb_q;      // Low byte lane enabled
   logic              wr_en;       // Write executes this cycle
   logic              wr_ok;       // Write address is mapped
   logic [7:0]        rd_val;      // Read data for araddr
   logic              rd_ok;       // Read address is mapped
   logic [NUM_CHAN-1:0] oe_q;      // timer_output_enable bits
   logic [NUM_CHAN-1:0] en_q;      // Count enabled per channel
   logic [NUM_CHAN-1:0] mode_q;    // 1: wait for ext pin edge
   logic [NUM_CHAN-1:0] trig_q;    // Trigger seen while enabled
   logic [NUM_CHAN-1:0] go;        // Counter may run
   logic [NUM_CHAN-1:0] done;      // Completion pulses
   logic [PER_W-1:0]  period_q [NUM_CHAN]; // Period values
   logic [PER_W-1:0]  count    [NUM_CHAN]; // Counter values
   logic [7:0]        ifl_q;       // irq_request_flags_low
   logic [7:0]        mkl_q;       // irq_mask_flags_low
   logic              mkh_q;       // chan1_low_done_mask
   logic [7:0]        ifl_set;     // Hardware request events
   logic [7:0]        ifl_clr;     // Software write-one clears
   logic              pend;        // Any unmasked request
   logic              ext_prev_q;  // Pin level last cycle
   logic              ext_rise;    // Pin rising edge
   logic [15:0]       div_q;       // Count clock divider
   logic              tick;        // One count clock

   ////////////////////////////////////////////////////////////////////
   // Write address and data channels, taken in either order
   assign wr_en = aw_q && w_q && !s_axi_bvalid_o;

   // Address channel holding register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_q            <= 1'b0;
         awaddr_q        <= '0;
         s_axi_awready_o <= 1'b1;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_q            <= 1'b1;
            awaddr_q        <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end else if (wr_en) begin
            aw_q            <= 1'b0;
            s_axi_awready_o <= 1'b1;
         end
      end
   end

   // Data channel holding register; registers use the low lane only
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         w_q            <= 1'b0;
         wdata_q        <= '0;
         wstb_q         <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end else if (ce_i) begin
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_q            <= 1'b1;
            wdata_q        <= s_axi_wdata_i[7:0];
            wstb_q         <= s_axi_wstrb_i[0];
            s_axi_wready_o <= 1'b0;
         end else if (wr_en) begin
            w_q            <= 1'b0;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // Mapped write addresses; unmapped ones answer SLVERR
   always_comb begin
      wr_ok = hit(awaddr_q, OFF_OE) || hit(awaddr_q, OFF_OUT) ||
              hit(awaddr_q, OFF_IFL) || hit(awaddr_q, OFF_MKL) ||
              hit(awaddr_q, OFF_MKH) || hit(awaddr_q, OFF_START) ||
              hit(awaddr_q, OFF_STOP) || hit(awaddr_q, OFF_MODE) ||
              hit(awaddr_q, OFF_STAT);
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (hit(awaddr_q, chan_off(OFF_PER0, i)) ||
             hit(awaddr_q, chan_off(OFF_CNT0, i))) begin
            wr_ok = 1'b1;
         end
      end
   end

   // Write response, one cycle after both halves are held
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (ce_i) begin
         if (wr_en) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read decode from the incoming address
   always_comb begin
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      if (hit(s_axi_araddr_i, OFF_OE)) begin
         rd_val = 8'(oe_q);
      end else if (hit(s_axi_araddr_i, OFF_OUT)) begin
         rd_val = 8'(tout_o);
      end else if (hit(s_axi_araddr_i, OFF_IFL)) begin
         rd_val = ifl_q;
      end else if (hit(s_axi_araddr_i, OFF_MKL)) begin
         rd_val = mkl_q;
      end else if (hit(s_axi_araddr_i, OFF_MKH)) begin
         rd_val = MKH_FIX | 8'(mkh_q);
      end else if (hit(s_axi_araddr_i, OFF_MODE)) begin
         rd_val = 8'(mode_q);
      end else if (hit(s_axi_araddr_i, OFF_STAT)) begin
         rd_val = 8'(en_q);
      end else if (!(hit(s_axi_araddr_i, OFF_START) ||
                     hit(s_axi_araddr_i, OFF_STOP))) begin
         // Trigger registers read zero; the rest is per channel
         rd_ok = 1'b0;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (hit(s_axi_araddr_i, chan_off(OFF_PER0, i))) begin
            rd_val = 8'(period_q[i]);
            rd_ok  = 1'b1;
         end
         if (hit(s_axi_araddr_i, chan_off(OFF_CNT0, i))) begin
            rd_val = 8'(count[i]);
            rd_ok  = 1'b1;
         end
      end
   end

   // Read channel: data registered at the address handshake
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= '0;
         s_axi_rresp_o   <= RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= {24'h000000, rd_val};
            s_axi_rresp_o   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers written by software
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         oe_q   <= '0;
         mode_q <= '0;
         mkl_q  <= MKL_RST;
         mkh_q  <= MKH_RST;
         for (int i = 0; i < NUM_CHAN; i++) begin
            period_q[i] <= '0;
         end
      end else if (ce_i && wr_en && wstb_q) begin
         if (hit(awaddr_q, OFF_OE)) begin
            oe_q <= wdata_q[NUM_CHAN-1:0];
         end
         if (hit(awaddr_q, OFF_MODE)) begin
            mode_q <= wdata_q[NUM_CHAN-1:0];
         end
         if (hit(awaddr_q, OFF_MKL)) begin
            mkl_q <= wdata_q & MKL_IMPL;
         end
         if (hit(awaddr_q, OFF_MKH)) begin
            mkh_q <= wdata_q[MKH_CH1_BIT];
         end
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (hit(awaddr_q, chan_off(OFF_PER0, i))) begin
               period_q[i] <= wdata_q[PER_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Count enable: start sets, stop clears, writing zero is a no-op
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q <= '0;
      end else if (ce_i && wr_en && wstb_q) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (hit(awaddr_q, OFF_START) && wdata_q[i]) begin
               en_q[i] <= 1'b1;
            end else if (hit(awaddr_q, OFF_STOP) && wdata_q[i]) begin
               en_q[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Count clock divider and external pin edge
   assign tick     = (div_q == DIV_LAST);
   assign ext_rise = ext_pin0_i && !ext_prev_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q      <= '0;
         ext_prev_q <= 1'b0;
      end else if (ce_i) begin
         div_q      <= tick ? 16'h0000 : div_q + 16'h0001;
         ext_prev_q <= ext_pin0_i;
      end
   end

   // Triggered mode waits for a pin edge after enabling
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_q <= '0;
      end else if (ce_i) begin
         trig_q <= en_q & (trig_q | {NUM_CHAN{ext_rise}});
      end
   end

   assign go = en_q & (~mode_q | trig_q);

   ////////////////////////////////////////////////////////////////////
   // Channel counters
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      chan_counter #(
         .PER_W    (PER_W)
      ) u_cnt (
         .mclk_i   (mclk_i),
         .rst_i    (rst_i),
         .ce_i     (ce_i),
         .go_i     (go[g]),
         .tick_i   (tick),
         .period_i (period_q[g]),
         .done_o   (done[g]),
         .count_o  (count[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Output bits: timer toggles when enabled, software otherwise
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tout_o <= '0;
      end else if (ce_i) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (oe_q[i]) begin
               // Software writes are dropped here
               if (done[i]) begin
                  tout_o[i] <= ~tout_o[i];
               end
            end else if (wr_en && wstb_q && hit(awaddr_q, OFF_OUT)) begin
               tout_o[i] <= wdata_q[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request flags: hardware set beats a write-one clear
   always_comb begin
      ifl_set               = 8'h00;
      ifl_set[IRQ_CH0_BIT]  = done[0];
      ifl_set[IRQ_CH1_BIT]  = done[1];
      ifl_set[IRQ_EXT0_BIT] = ext_rise;
      ifl_clr = (wr_en && wstb_q && hit(awaddr_q, OFF_IFL)) ?
                wdata_q : 8'h00;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ifl_q <= IFL_RST;
      end else if (ce_i) begin
         ifl_q <= ifl_set | (ifl_q & ~ifl_clr);
      end
   end

   // Channel 1 is blocked by either of its two mask bits
   assign pend = (ifl_q[IRQ_CH0_BIT] && !mkl_q[IRQ_CH0_BIT]) ||
                 (ifl_q[IRQ_CH1_BIT] && !mkl_q[IRQ_CH1_BIT] && !mkh_q) ||
                 (ifl_q[IRQ_EXT0_BIT] && !mkl_q[IRQ_EXT0_BIT]);

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= pend;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sw_out_taken_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && wr_en && wstb_q && hit(awaddr_q, OFF_OUT) && !oe_q[1])
      |=> tout_o[1] == $past(wdata_q[1]))
      else $error("software output level not taken");

   sw_out_ignored_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && oe_q[1] && !done[1]) |=> $stable(tout_o[1]))
      else $error("enabled output changed without completion");

   timer_toggle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && oe_q[1] && done[1]) |=> tout_o[1] != $past(tout_o[1]))
      else $error("enabled output did not toggle on completion");

   oe_upper_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (s_axi_rvalid_o && $rose(s_axi_rvalid_o) &&
       hit($past(s_axi_araddr_i), OFF_OE))
      |-> s_axi_rdata_o[7:NUM_CHAN] == '0)
      else $error("unused enable bits read nonzero");

   done_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && done[1]) |=> ifl_q[IRQ_CH1_BIT])
      else $error("channel 1 completion lost its request");

   mask_block_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mkl_q == MKL_IMPL && mkh_q) |=> !irq_o)
      else $error("interrupt raised with all sources masked");

   unmasked_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && ifl_q[IRQ_CH0_BIT] && !mkl_q[IRQ_CH0_BIT]) |=> irq_o)
      else $error("unmasked channel 0 request not signalled");

   start_sets_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && wr_en && wstb_q && hit(awaddr_q, OFF_START) && wdata_q[1])
      |=> en_q[1])
      else $error("start trigger did not enable channel 1");

   trig_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (en_q[1] && mode_q[1] && !trig_q[1]) |=> $stable(count[1]))
      else $error("triggered channel ran before its pin edge");

endmodule

`default_nettype wire

//--- testbench/timer_channel_output_irq_ctrl_tb_top.sv
// Bench for the timer channel block: registers, output pins, irq.
// Assumes the package offsets, NUM_CHAN 2 and COUNT_DIV 1.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_output_irq_ctrl_tb_top import timer_pkg::*; ;
   logic        mclk = 1'b0, rst = 1'b1, ext = 1'b0; // Clock, reset, pin
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0;   // Write master side
   logic        arv = 1'b0, rre = 1'b0;              // Read master side
   logic [7:0]  awa = 8'h00, ara = 8'h00;            // Addresses
   logic [31:0] wd = 32'h0;                          // Write data
   wire logic   awr, wr, bv, arr, rv, irq;           // Slave answers
   wire logic [1:0]  bresp, rresp, tout;
   wire logic [31:0] rd;
   int          n_mismatch = 0, n_tests = 0;
   timer_channel_output_irq_ctrl i_dut (.mclk_i(mclk), .rst_i(rst),
      .ce_i(1'b1), .ext_pin0_i(ext), .s_axi_awvalid_i(awv),
      .s_axi_awaddr_i(awa), .s_axi_awready_o(awr), .s_axi_wvalid_i(wv),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wready_o(wr),
      .s_axi_bvalid_o(bv), .s_axi_bresp_o(bresp), .s_axi_bready_i(bre),
      .s_axi_arvalid_i(arv), .s_axi_araddr_i(ara), .s_axi_arready_o(arr),
      .s_axi_rvalid_o(rv), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
      .s_axi_rready_i(rre), .tout_o(tout), .irq_o(irq));
   // 10 MHz clock
   initial begin
      forever #50 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Case equality so an unknown never passes
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tmo();
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      end_sim();
   endtask
   // One write; each channel dropped at its own handshake
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      int n;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      if (n == 50) tmo();
      chk(32'(bresp), 32'(RESP_OKAY));
      bre <= 1'b0;
      @(posedge mclk); // Spacing so no signal is set twice at one edge
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
      int n;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      if (n == 50) tmo();
      d = rd;
      r = rresp;
      rre <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rreg(a, d, r);
      chk(d, e);
   endtask
   // Cycles until the channel 0 pin changes
   task automatic wtog(output int g);
      logic o;
      o = tout[0];
      for (g = 1; g < 100; g++) begin
         @(posedge mclk);
         if (tout[0] !== o) break;
      end
      if (g == 100) tmo();
   endtask
   // Irq level settles within a few cycles; a miss ends the run
   task automatic wirq(input logic e);
      for (int n = 0; n < 50 && irq !== e; n++) @(posedge mclk);
      chk(32'(irq), 32'(e));
      if (irq !== e) end_sim();
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      rchk(OFF_OE, 32'h0);
      rchk(OFF_IFL, 32'h0);
      rchk(OFF_MKL, 32'hC2);
      rchk(OFF_MKH, 32'hF9);
      rreg(8'h80, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      wreg(OFF_OE, 32'hFF);
      rchk(OFF_OE, 32'h3);
      wreg(OFF_OE, 32'h0);
   endtask
   task automatic t_out();
      wreg(OFF_OUT, 32'h3);
      chk(32'(tout), 32'h3);
      wreg(OFF_OE, 32'h1);
      wreg(OFF_OUT, 32'h0);
      chk(32'(tout), 32'h1);
      wreg(OFF_OE, 32'h0);
      wreg(OFF_OUT, 32'h0);
      chk(32'(tout), 32'h0);
   endtask
   // First gap is partial: counting began during the start write
   task automatic t_period();
      int g;
      wreg(OFF_PER0, 32'h3);
      wreg(OFF_OE, 32'h1);
      wreg(OFF_MKL, 32'h42);
      wreg(OFF_START, 32'h0);
      rchk(OFF_STAT, 32'h0);
      wreg(OFF_START, 32'h1);
      rchk(OFF_STAT, 32'h1);
      wtog(g);
      wtog(g);
      chk(32'(g), 32'd4);
      wtog(g);
      chk(32'(g), 32'd4);
      wirq(1'b1);
      wreg(OFF_STOP, 32'h1);
      wreg(OFF_OE, 32'h0);
   endtask
   // Triggered start: counting waits for the pin's rising edge
   task automatic t_trig();
      logic o;
      int   g;
      wreg(OFF_MODE, 32'h1);
      wreg(OFF_OE, 32'h1);
      wreg(OFF_START, 32'h1);
      o = tout[0];
      repeat (10) @(posedge mclk);
      chk(32'(tout[0]), 32'(o));
      ext <= 1'b1;
      @(posedge mclk);
      ext <= 1'b0;
      wtog(g);
      wtog(g);
      chk(32'(g), 32'd4);
      wreg(OFF_STOP, 32'h1);
      wreg(OFF_MODE, 32'h0);
      wreg(OFF_OE, 32'h0);
   endtask
   task automatic t_irq();
      wreg(OFF_IFL, 32'hFF);
      wreg(OFF_MKH, 32'h0);
      wreg(OFF_MKL, 32'h82);
      wreg(OFF_PER0 + CHAN_STEP, 32'h2);
      wreg(OFF_OE, 32'h2);
      wreg(OFF_START, 32'h2);
      wirq(1'b1);
      wreg(OFF_STOP, 32'h2);
      rchk(OFF_IFL, 32'h40);
      wreg(OFF_MKH, 32'h1);
      wirq(1'b0);
      wreg(OFF_IFL, 32'h40);
      rchk(OFF_IFL, 32'h0);
      ext <= 1'b1;
      repeat (2) @(posedge mclk);
      ext <= 1'b0;
      rchk(OFF_IFL, 32'h2);
      chk(32'(irq), 32'h0);
      wreg(OFF_MKL, 32'h80);
      wirq(1'b1);
      wreg(OFF_IFL, 32'h2);
      wirq(1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_out();
      t_period();
      t_trig();
      t_irq();
      end_sim();
   end
endmodule
`default_nettype wire
